// ===== tcl_pkg.sv
// Constants shared by the trajectory command loader and its helpers.
// Assumes a single 250 MHz clock domain and an APB register port.
package tcl_pkg;
    // Command codes seen on the command register
    localparam logic [7:0]  CMD_LOAD_TRJ   = 8'h1f;
    localparam logic [7:0]  CMD_START      = 8'h01;
    // Register byte offsets
    localparam logic [7:0]  OFS_CMD        = 8'h00;
    localparam logic [7:0]  OFS_DATA       = 8'h04;
    localparam logic [7:0]  OFS_STATUS     = 8'h08;
    localparam logic [7:0]  OFS_SIGNALS    = 8'h0c;
    localparam logic [7:0]  OFS_ACC        = 8'h10;
    localparam logic [7:0]  OFS_VEL        = 8'h14;
    localparam logic [7:0]  OFS_POS        = 8'h18;
    localparam logic [7:0]  OFS_CLEAR      = 8'h1c;
    // Trajectory control word fields
    localparam int          CW_FWD         = 12;
    localparam int          CW_VEL         = 11;
    localparam int          CW_SMOOTH      = 10;
    localparam int          CW_ABRUPT      = 9;
    localparam int          CW_OFF         = 8;
    localparam int          CW_ACC_LD      = 5;
    localparam int          CW_ACC_REL     = 4;
    localparam int          CW_VEL_LD      = 3;
    localparam int          CW_VEL_REL     = 2;
    localparam int          CW_POS_LD      = 1;
    localparam int          CW_POS_REL     = 0;
    // Status and signals register fields
    localparam int          ST_BUSY        = 0;
    localparam int          ST_CMD_ERR     = 1;
    localparam int          ST_TRJ_DONE    = 2;
    localparam int          ST_MOTOR_OFF   = 7;
    localparam int          SG_FWD         = 12;
    localparam int          SG_VEL_MODE    = 11;
    localparam int          SG_ACC_LOADED  = 14;
    localparam int          SG_MOVING      = 16;
    localparam logic [15:0] CW_RESET       = 16'h0000;
    // Motor drive code meaning zero drive (offset binary half scale)
    localparam logic [11:0] MOTOR_ZERO     = 12'h800;
    // Busy time after each accepted byte
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          BUSY_NS        = 16;
    localparam int          BUSY_CYC       = (BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Parser states
    typedef enum logic [1:0] {TCL_IDLE, TCL_CW, TCL_PARAM} tcl_state_t;
endpackage : tcl_pkg

// ===== tcl_pair_asm.sv
// Byte pair assembler: two bytes, high byte first, make one 16-bit word.
// Assumes byte strobes from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tcl_pair_asm (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Byte side
    input  wire logic        clr,
    input  wire logic        byte_vld,
    input  wire logic [7:0]  byte_in,
    // Word side
    output logic             word_vld,
    output logic [15:0]      word
);
    logic       half_r;
    logic [7:0] hi_r;

    // High byte arrives first; clr drops any half pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            half_r   <= 1'b0;
            hi_r     <= 8'h00;
            word_vld <= 1'b0;
            word     <= 16'h0000;
        end else begin
            word_vld <= 1'b0;
            if (clr) begin
                half_r <= 1'b0;
            end else if (byte_vld) begin
                half_r <= ~half_r;
                if (half_r) begin
                    word_vld <= 1'b1;
                    word     <= {hi_r, byte_in};
                end else begin
                    hi_r <= byte_in;
                end
            end
        end
    end
endmodule : tcl_pair_asm
`default_nettype wire

// ===== tcl_param_buf.sv
// Double buffered trajectory parameter: primary buffer and working value.
// Assumes load and start never fall in the same cycle from one source.
`timescale 1ns/100ps
`default_nettype none
module tcl_param_buf #(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Primary side
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         load_rel,
    // Transfer side
    input  wire logic         start,
    input  wire logic         force_en,
    input  wire logic [W-1:0] force_val,
    output logic [W-1:0]      work
);
    logic [W-1:0] prim_r;
    logic         rel_r;
    logic         pend_r;

    // Primary buffer; only loaded values transfer later
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prim_r <= '0;
            rel_r  <= 1'b0;
            pend_r <= 1'b0;
        end else if (load) begin
            prim_r <= load_val;
            rel_r  <= load_rel;
            pend_r <= 1'b1;
        end else if (start) begin
            pend_r <= 1'b0;
        end
    end

    // Working value moves only on start; relative adds, absolute replaces
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work <= '0;
        end else if (start) begin
            if (force_en) begin
                work <= force_val;
            end else if (pend_r) begin
                work <= rel_r ? work + prim_r : prim_r;
            end
        end
    end
endmodule : tcl_param_buf
`default_nettype wire

// ===== tcl_loader.sv
// Trajectory command loader: parses load and start commands written over
// APB and holds the working trajectory for the profile generator.
// Assumes motion inputs come from logic on pclk; no synchronisers needed.
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
// Operation
// [RULE1] Control word follows load command as two bytes, high byte first.
// [RULE2] Bit 12 picks forward direction in velocity mode, ignored otherwise.
// [RULE3] Bit 11 selects velocity mode when one, position mode when zero.
// [RULE4] Bit 8 turns motor off by driving the zero drive code.
// [RULE5] Bit 9 stops abruptly by making target equal current position.
// [RULE6] Bit 10 decelerates smoothly with the programmed acceleration.
// [RULE7] Host sets at most one of bits 8 to 10.
// [RULE8] Position mode stops smoothly by itself at trajectory end.
// [RULE9] Bits 5,3,1 flag loads; bits 4,2,0 mark them relative.
// [RULE10] Each parameter is two words, word and byte high first.
// [RULE11] Selected parameters follow in order acceleration, velocity, position.
// [RULE12] Host keeps acceleration and velocity positive, below limit.
// [RULE13] Acceleration and velocity carry 16 fraction bits below bit 16.
// [RULE14] Host never loads acceleration above velocity.
// [RULE15] Position is a signed 32-bit two's complement value.
// [RULE16] Loads fill primary buffers; start copies them to working registers.
// [RULE17] Start command code 01, no data, launches latest trajectory.
// [RULE18] New parameters are accepted any time, even during motion.
// [RULE19] Host waits for move end before start after acceleration change.
// [RULE20] Start during motion after acceleration change is ignored, error raised.
// [RULE21] Start transfers everything at once so axes start together.
// [RULE22] Reports other than status need a command write, then data read; here every report reads directly at its own address.
// [RULE23] Load command code is 1F, taking two to fourteen bytes.
// [RULE24] Command and data writes while busy are ignored.
// [RULE25] Acceleration loaded flag sets on load, clears on start.
// [RULE26] Relative parameters add to working value at start.
module tcl_loader (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Profile generator side
    input  wire logic        motion_done,
    input  wire logic [31:0] cur_pos,
    input  wire logic [11:0] filt_drive,
    output logic [31:0]      work_acc,
    output logic [31:0]      work_vel,
    output logic [31:0]      work_pos,
    output logic             vel_mode,
    output logic             fwd_dir,
    output logic             stop_smooth,
    output logic             auto_stop_en,
    output logic             start_pulse,
    output logic             moving,
    output logic             motor_off,
    output logic [11:0]      motor_drive
);
    localparam int BUSY_W = $clog2(tcl_pkg::BUSY_CYC + 1);

    if (tcl_pkg::BUSY_CYC < 1) begin : g_chk
        $error("Busy time must be at least one cycle");
    end

    tcl_pkg::tcl_state_t state_r;
    logic [BUSY_W-1:0]   busy_cnt_r;
    logic [15:0]         cw_prim_r;
    logic [2:0]          sel_r;
    logic                half_r;
    logic [15:0]         hi_word_r;
    logic                acc_loaded_r;
    logic                cmd_err_r;
    logic                trj_done_r;
    logic [31:0]         rd_nxt;
    logic                hit;
    logic                access;
    logic                busy;
    logic                cmd_wr;
    logic                data_wr;
    logic                clr_wr;
    logic                start_req;
    logic                start_rej;
    logic                start_ok;
    logic                word_vld;
    logic [15:0]         word;
    logic                ld_acc;
    logic                ld_vel;
    logic                ld_pos;
    logic [31:0]         param_val;

    // APB decode; zero wait states, unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign access  = psel & penable;
    assign busy    = (busy_cnt_r != '0);
    assign cmd_wr  = access & pwrite & (paddr == tcl_pkg::OFS_CMD) & ~busy;   // [RULE24]
    assign data_wr = access & pwrite & (paddr == tcl_pkg::OFS_DATA) & ~busy;  // [RULE24]
    assign clr_wr  = access & pwrite & (paddr == tcl_pkg::OFS_CLEAR);
    assign pslverr = access & ~hit;

    // Start attempt and its refusal while moving with a changed acceleration pending
    assign start_req = cmd_wr & (pwdata[7:0] == tcl_pkg::CMD_START);   // [RULE17]
    assign start_rej = start_req & moving & acc_loaded_r;             // [RULE20]
    assign start_ok  = start_req & ~start_rej;

    // Busy window after each accepted byte; polled by software before each byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt_r <= '0;
        end else if (cmd_wr | data_wr) begin
            busy_cnt_r <= BUSY_W'(tcl_pkg::BUSY_CYC);                 // [RULE24]
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 1'b1;
        end
    end

    tcl_pair_asm u_pair (
        .clk      (pclk),
        .rst_n    (presetn),
        .clr      (cmd_wr),
        .byte_vld (data_wr && state_r != tcl_pkg::TCL_IDLE),   // [RULE18]
        .byte_in  (pwdata[7:0]),
        .word_vld (word_vld),
        .word     (word)
    );

    // Parser: control word, then two words per selected parameter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= tcl_pkg::TCL_IDLE;
            cw_prim_r <= tcl_pkg::CW_RESET;
            sel_r     <= 3'b000;
            half_r    <= 1'b0;
            hi_word_r <= 16'h0000;
        end else if (cmd_wr) begin
            half_r  <= 1'b0;
            state_r <= (pwdata[7:0] == tcl_pkg::CMD_LOAD_TRJ) ? tcl_pkg::TCL_CW   // [RULE23]
                                                              : tcl_pkg::TCL_IDLE;
        end else if (word_vld) begin
            case (state_r)
                tcl_pkg::TCL_CW: begin
                    cw_prim_r <= word;                                          // [RULE1]
                    sel_r     <= {word[tcl_pkg::CW_ACC_LD], word[tcl_pkg::CW_VEL_LD],
                                  word[tcl_pkg::CW_POS_LD]};                    // [RULE9]
                    state_r   <= (word[tcl_pkg::CW_ACC_LD] | word[tcl_pkg::CW_VEL_LD] |
                                  word[tcl_pkg::CW_POS_LD]) ? tcl_pkg::TCL_PARAM
                                                            : tcl_pkg::TCL_IDLE;
                end
                tcl_pkg::TCL_PARAM: begin
                    half_r <= ~half_r;
                    if (!half_r) begin
                        hi_word_r <= word;                                      // [RULE10]
                    end else begin
                        // Drop the parameter just taken, highest order first
                        if (sel_r[2]) begin
                            sel_r[2] <= 1'b0;
                        end else if (sel_r[1]) begin
                            sel_r[1] <= 1'b0;
                        end else begin
                            sel_r[0] <= 1'b0;
                        end
                        if ((sel_r[2] ? 2'd1 : 2'd0) + (sel_r[1] ? 2'd1 : 2'd0) +
                            (sel_r[0] ? 2'd1 : 2'd0) == 2'd1) begin
                            state_r <= tcl_pkg::TCL_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= tcl_pkg::TCL_IDLE;
                end
            endcase
        end
    end

    // Second word of a pair completes a parameter; order acc, vel, pos
    assign param_val = {hi_word_r, word};
    assign ld_acc = word_vld & (state_r == tcl_pkg::TCL_PARAM) & half_r & sel_r[2];      // [RULE11]
    assign ld_vel = word_vld & (state_r == tcl_pkg::TCL_PARAM) & half_r & ~sel_r[2] & sel_r[1];
    assign ld_pos = word_vld & (state_r == tcl_pkg::TCL_PARAM) & half_r & ~sel_r[2] & ~sel_r[1]
                    & sel_r[0];

    // Acceleration and velocity keep 16 fraction bits; stored unchanged
    tcl_param_buf #(.W(32)) u_acc (
        .clk       (pclk),
        .rst_n     (presetn),
        .load      (ld_acc),
        .load_val  (param_val),                                             // [RULE13]
        .load_rel  (cw_prim_r[tcl_pkg::CW_ACC_REL]),
        .start     (start_ok),
        .force_en  (1'b0),
        .force_val (32'h0000_0000),
        .work      (work_acc)
    );

    tcl_param_buf #(.W(32)) u_vel (
        .clk       (pclk),
        .rst_n     (presetn),
        .load      (ld_vel),
        .load_val  (param_val),
        .load_rel  (cw_prim_r[tcl_pkg::CW_VEL_REL]),                        // [RULE26]
        .start     (start_ok),                                              // [RULE16]
        .force_en  (1'b0),
        .force_val (32'h0000_0000),
        .work      (work_vel)
    );

    // Position is two's complement; relative adds wrap like signed sums
    tcl_param_buf #(.W(32)) u_pos (
        .clk       (pclk),
        .rst_n     (presetn),
        .load      (ld_pos),
        .load_val  (param_val),                                             // [RULE15]
        .load_rel  (cw_prim_r[tcl_pkg::CW_POS_REL]),
        .start     (start_ok),                                              // [RULE21]
        .force_en  (cw_prim_r[tcl_pkg::CW_ABRUPT]),                         // [RULE5]
        .force_val (cur_pos),
        .work      (work_pos)
    );

    // Mode and stop bits take effect only at start, same edge as the data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vel_mode     <= 1'b0;
            fwd_dir      <= 1'b0;
            stop_smooth  <= 1'b0;
            auto_stop_en <= 1'b1;
            start_pulse  <= 1'b0;
        end else begin
            start_pulse <= start_ok;                                        // [RULE21]
            if (start_ok) begin
                vel_mode     <= cw_prim_r[tcl_pkg::CW_VEL];                 // [RULE3]
                fwd_dir      <= cw_prim_r[tcl_pkg::CW_VEL] & cw_prim_r[tcl_pkg::CW_FWD];  // [RULE2]
                stop_smooth  <= cw_prim_r[tcl_pkg::CW_SMOOTH];              // [RULE6]
                auto_stop_en <= ~cw_prim_r[tcl_pkg::CW_VEL];                // [RULE8]
            end
        end
    end

    // Motion and motor-off state; motor-off only lands when start runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            moving    <= 1'b0;
            motor_off <= 1'b1;
        end else if (start_ok) begin
            motor_off <= cw_prim_r[tcl_pkg::CW_OFF];                        // [RULE4]
            moving    <= ~cw_prim_r[tcl_pkg::CW_OFF];
        end else if (motion_done) begin
            moving <= 1'b0;
        end
    end

    // Zero drive code replaces the filter output while the motor is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            motor_drive <= tcl_pkg::MOTOR_ZERO;
        end else begin
            motor_drive <= motor_off ? tcl_pkg::MOTOR_ZERO : filt_drive;    // [RULE4]
        end
    end

    // Sticky flags; a set in the same cycle as a clear wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_loaded_r <= 1'b0;
            cmd_err_r    <= 1'b0;
            trj_done_r   <= 1'b0;
        end else begin
            if (ld_acc) begin
                acc_loaded_r <= 1'b1;                                       // [RULE25]
            end else if (start_ok) begin
                acc_loaded_r <= 1'b0;
            end
            if (start_rej) begin
                cmd_err_r <= 1'b1;                                          // [RULE20]
            end else if (clr_wr && pwdata[tcl_pkg::ST_CMD_ERR]) begin
                cmd_err_r <= 1'b0;
            end
            if (motion_done && moving) begin
                trj_done_r <= 1'b1;
            end else if (clr_wr && pwdata[tcl_pkg::ST_TRJ_DONE]) begin
                trj_done_r <= 1'b0;
            end
        end
    end

    // Read mux; every report, status included, reads directly with no prior command
    always_comb begin
        rd_nxt = 32'h0000_0000;
        hit    = 1'b1;
        case (paddr)
            tcl_pkg::OFS_CMD, tcl_pkg::OFS_DATA, tcl_pkg::OFS_CLEAR: begin
                rd_nxt = 32'h0000_0000;
            end
            tcl_pkg::OFS_STATUS: begin
                rd_nxt[tcl_pkg::ST_BUSY]      = busy;                       // [RULE22]
                rd_nxt[tcl_pkg::ST_CMD_ERR]   = cmd_err_r;
                rd_nxt[tcl_pkg::ST_TRJ_DONE]  = trj_done_r;
                rd_nxt[tcl_pkg::ST_MOTOR_OFF] = motor_off;
            end
            tcl_pkg::OFS_SIGNALS: begin
                rd_nxt[tcl_pkg::ST_CMD_ERR]    = cmd_err_r;
                rd_nxt[tcl_pkg::ST_TRJ_DONE]   = trj_done_r;
                rd_nxt[tcl_pkg::ST_MOTOR_OFF]  = motor_off;
                rd_nxt[tcl_pkg::SG_VEL_MODE]   = vel_mode;
                rd_nxt[tcl_pkg::SG_FWD]        = fwd_dir;
                rd_nxt[tcl_pkg::SG_ACC_LOADED] = acc_loaded_r;
                rd_nxt[tcl_pkg::SG_MOVING]     = moving;
            end
            tcl_pkg::OFS_ACC: begin
                rd_nxt = work_acc;
            end
            tcl_pkg::OFS_VEL: begin
                rd_nxt = work_vel;
            end
            tcl_pkg::OFS_POS: begin
                rd_nxt = work_pos;
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    // Read data captured in the setup phase so it is a flop in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata <= rd_nxt;
        end
    end

    // Checks
    sequence s_start_refused;
        start_req && moving && acc_loaded_r;
    endsequence

    sequence s_start_taken;
        start_req && !(moving && acc_loaded_r);
    endsequence

    a_cw_capture: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
        word_vld && state_r == tcl_pkg::TCL_CW |=> cw_prim_r == $past(word))
        else $error("Control word not captured");

    a_fwd_vel_only: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
        fwd_dir |-> vel_mode)
        else $error("Forward set outside velocity mode");

    a_mode_on_start: assert property (@(posedge pclk) disable iff (!presetn) // [RULE3]
        s_start_taken |=> vel_mode == $past(cw_prim_r[tcl_pkg::CW_VEL]) && start_pulse)
        else $error("Mode not applied at start");

    a_motor_zero: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
        motor_off |=> motor_drive == tcl_pkg::MOTOR_ZERO)
        else $error("Drive not zero while motor off");

    a_abrupt_target: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
        s_start_taken ##0 cw_prim_r[tcl_pkg::CW_ABRUPT] |=> work_pos == $past(cur_pos))
        else $error("Abrupt stop target wrong");

    a_smooth_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
        s_start_taken |=> stop_smooth == $past(cw_prim_r[tcl_pkg::CW_SMOOTH]))
        else $error("Smooth stop not applied");

    a_pos_auto_stop: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
        start_pulse |-> auto_stop_en == !vel_mode)
        else $error("Auto stop not tied to position mode");

    a_start_refused: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
        s_start_refused |=> cmd_err_r && !start_pulse && $stable(work_pos))
        else $error("Refused start took effect");

    a_acc_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE25]
        ld_acc |=> acc_loaded_r ##1 (acc_loaded_r || $past(start_ok)))
        else $error("Acceleration loaded flag wrong");

    a_busy_ignore: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
        access && pwrite && busy && paddr == tcl_pkg::OFS_CMD |=> !start_pulse && $stable(state_r))
        else $error("Write accepted while busy");

    a_start_transfer: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
        !start_ok |=> $stable(work_acc) && $stable(work_vel))
        else $error("Working value changed without start");
endmodule : tcl_loader
`default_nettype wire

// ===== tcl_host.sv
// Host model: APB master writing command and data bytes.
// Assumes a slave on clk; each byte waits for busy low.
`timescale 1ns/100ps
`default_nettype none
module tcl_host (
    // Bus in
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    // Bus out
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata
);
    logic err;
    // Bus idle at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
    end
    // Setup, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : xfer
    // Busy is polled first, as writes during busy are dropped
    task automatic put(input logic [7:0] a, input logic [7:0] b);
        logic [31:0] s;
        s = 32'h1;
        while (s[0] !== 1'b0) xfer(1'b0, tcl_pkg::OFS_STATUS, 32'h0, s);
        xfer(1'b1, a, {24'h0, b}, s);
    endtask : put
    // Control word high byte first, then selected values in acc, vel, pos order
    task automatic load(input logic [15:0] cw, input logic [95:0] v);
        put(tcl_pkg::OFS_CMD, tcl_pkg::CMD_LOAD_TRJ);
        put(tcl_pkg::OFS_DATA, cw[15:8]);
        put(tcl_pkg::OFS_DATA, cw[7:0]);
        for (int p = 2; p >= 0; p--)
            if (cw[2*p+1])
                for (int k = 3; k >= 0; k--) put(tcl_pkg::OFS_DATA, v[32*p+8*k +: 8]);
    endtask : load
endmodule : tcl_host
`default_nettype wire

// ===== trajectory_command_loader_bench.sv
// Bench for the trajectory command loader with the host model on APB.
// Assumes the bench plays the profile generator side.
`timescale 1ns/100ps
`default_nettype none
module trajectory_command_loader_bench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, motion_done;
    logic vel_mode, fwd_dir, stop_smooth, auto_stop_en, start_pulse, moving, motor_off;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, cur_pos, r, work_acc, work_vel, work_pos;
    logic [11:0] filt_drive, motor_drive;
    int error_cnt = 0;
    int checks_done = 0;
    tcl_loader dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .motion_done, .cur_pos, .filt_drive, .work_acc, .work_vel, .work_pos, .vel_mode,
        .fwd_dir, .stop_smooth, .auto_stop_en, .start_pulse, .moving, .motor_off, .motor_drive);
    tcl_host h (.clk(pclk), .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    // Clock, 4 ns period
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a);
        h.xfer(1'b0, a, 32'h0, r);
    endtask : rd
    // Working values land the cycle after the start is taken
    task automatic go();
        h.put(tcl_pkg::OFS_CMD, tcl_pkg::CMD_START);
        repeat (3) @(posedge pclk);
    endtask : go
    task automatic s_load();
        h.load(16'h182a, {32'h0002_0000, 32'h0005_0000, 32'h0000_1234});
        chk("acc early", work_acc, 32'h0);
        rd(tcl_pkg::OFS_SIGNALS);
        chk("acc flag", r[14], 1'b1);
        go();
        chk("acc", work_acc, 32'h0002_0000);
        chk("vel", work_vel, 32'h0005_0000);
        chk("pos", work_pos, 32'h0000_1234);
        chk("mode", {vel_mode, fwd_dir, moving, auto_stop_en}, 4'b1110);
        rd(tcl_pkg::OFS_SIGNALS);
        chk("acc flag off", r[14], 1'b0);
    endtask : s_load
    task automatic s_err();
        h.load(16'h0020, {32'h0001_0000, 64'h0});
        go();
        rd(tcl_pkg::OFS_STATUS);
        chk("cmd err", r[1], 1'b1);
        chk("acc kept", work_acc, 32'h0002_0000);
        h.xfer(1'b1, tcl_pkg::OFS_CLEAR, 32'h2, r);
        @(posedge pclk) motion_done <= 1'b1;
        @(posedge pclk) motion_done <= 1'b0;
        go(); // Host waits for move end after an acc change
        chk("acc new", work_acc, 32'h0001_0000);
        h.load(16'h0003, {64'h0, 32'h0000_0010});
        go();
        chk("rel pos", work_pos, 32'h0000_1244);
        chk("pos mode", {vel_mode, fwd_dir, auto_stop_en}, 3'b001);
    endtask : s_err
    // One stop bit per control word
    task automatic s_stop();
        chk("drive", motor_drive, 12'h123);
        h.load(16'h0200, 96'h0);
        go();
        chk("abrupt", work_pos, 32'h777);
        h.load(16'h0400, 96'h0);
        go();
        chk("smooth", stop_smooth, 1'b1);
        h.load(16'h0100, 96'h0);
        h.xfer(1'b1, tcl_pkg::OFS_CMD, 32'h1, r);
        @(posedge pclk) chk("busy drop", motor_off, 1'b0);
        go();
        chk("off", {motor_off, motor_drive}, {1'b1, tcl_pkg::MOTOR_ZERO});
        h.xfer(1'b0, 8'hf0, 32'h0, r);
        chk("unmapped", h.err, 1'b1);
    endtask : s_stop
    task automatic results();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    initial begin
        {presetn, motion_done, cur_pos, filt_drive} = {2'b00, 32'h777, 12'h123};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        s_load();
        s_err();
        s_stop();
        results();
    end
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        results();
    end
endmodule : trajectory_command_loader_bench
`default_nettype wire
